// ### epw_consts.vh
/*
 header of constants for the page-write host controller.
 assumes a 20 MHz system clock; included by bare name.
*/
`ifndef EPW_CONSTS_VH
`define EPW_CONSTS_VH

`define EPW_CLK_MHZ        20
`define EPW_PAGE_BYTES     32
`define EPW_COL_BITS       5
`define EPW_ADDR_BITS      13
`define EPW_DATA_BITS      8
`define EPW_TOP_BIT        7
// write pulse, setup and hold widths in ns
`define EPW_WP_NS          100
`define EPW_SETUP_NS       50
`define EPW_HOLD_NS        80
// longest gap between strobes in us
`define EPW_GAP_MAX_US     30
// power-up lockout and write period in ms
`define EPW_LOCK_MS        5
`define EPW_TWC_MS         5
// cycles: least times round up, longest gap is halved and rounds down
`define EPW_WP_CYC    ((`EPW_WP_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_SETUP_CYC ((`EPW_SETUP_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_HOLD_CYC  ((`EPW_HOLD_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_GAP_CYC   ((`EPW_GAP_MAX_US * `EPW_CLK_MHZ) / 2)
`define EPW_LOCK_CYC  (`EPW_LOCK_MS * 1000 * `EPW_CLK_MHZ)
`define EPW_TWC_CYC   (`EPW_TWC_MS * 1000 * `EPW_CLK_MHZ)
`define EPW_CNT_BITS       20
`define EPW_POLL_CYC       4

`endif

// ### epw_sync.v
/*
 two-flop synchroniser for one level.
 assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module epw_sync (
   input  wire clk,
   input  wire arst_n,
   input  wire din,
   output reg  dout
);
   reg meta_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b1;
         dout   <= 1'b1;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// ### epw_host.v
/*
 host controller that writes pages into a byte-wide eeprom through
 its chip select, output gate and write strobe pins, then waits for
 completion by status polling or by the ready/busy line.
 assumes an external pull-up on the ready/busy line and that the data
 bus is resolved outside from dataOe_n.
*/
// Overview of operation
// - strobe low with select low, gate high
// - keep strobe gaps under 30us (not enforced: S_WAIT waits for byteValid without a limit)
// - hold write-inhibit levels when idle
// - busy pin open drain, pulled up
`timescale 1ns/1ns
`include "epw_consts.vh"
module epw_host (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        startReq,
   input  wire        ceMode,
   input  wire        usePoll,
   input  wire [7:0]  pageRow,
   input  wire [5:0]  byteCount,
   input  wire [4:0]  colIn,
   input  wire [7:0]  dataIn,
   input  wire        byteValid,
   output reg         byteReady_q,
   output reg         busy_q,
   output reg         done_q,
   output reg  [12:0] addr_q,
   output reg  [7:0]  dataOut_q,
   output reg         dataOe_n_q,
   output reg         chipSel_n_q,
   output reg         outGate_n_q,
   output reg         wrStrobe_n_q,
   input  wire [7:0]  dataPin,
   input  wire        writeDonePin
);
   localparam S_LOCK = 4'h0;
   localparam S_IDLE = 4'h1;
   localparam S_WAIT = 4'h2;
   localparam S_SET  = 4'h3;
   localparam S_PULS = 4'h4;
   localparam S_HOLD = 4'h5;
   localparam S_RDA  = 4'h6;
   localparam S_RDB  = 4'h7;
   localparam S_RDC  = 4'h8;
   localparam S_DONE = 4'h9;

   reg [3:0]  state_q;
   reg [19:0] cnt_q;
   reg [5:0]  left_q;
   reg [19:0] gap_q;
   reg        lastTop_q;
   reg        ceMode_q;
   reg        poll_q;
   wire [7:0] dataSync;
   wire       rdySync;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : gSync
         epw_sync uSyncD (
            .clk    (clk),
            .arst_n (arst_n),
            .din    (dataPin[gi]),
            .dout   (dataSync[gi])
         );
      end
   endgenerate

   epw_sync uSyncR (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (writeDonePin),
      .dout   (rdySync)
   );

   function [19:0] cyc;
      input integer n;
      cyc = n[19:0];
   endfunction

   // =====================================================
   // sequencer
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= S_LOCK;
         cnt_q        <= 20'h00000;
         left_q       <= 6'h00;
         gap_q        <= 20'h00000;
         lastTop_q    <= 1'b0;
         ceMode_q     <= 1'b0;
         poll_q       <= 1'b0;
         byteReady_q  <= 1'b0;
         busy_q       <= 1'b1;
         done_q       <= 1'b0;
         addr_q       <= 13'h0000;
         dataOut_q    <= 8'h00;
         dataOe_n_q   <= 1'b1;
         chipSel_n_q  <= 1'b1;
         outGate_n_q  <= 1'b1;
         wrStrobe_n_q <= 1'b1;
      end else begin
         done_q      <= 1'b0;
         byteReady_q <= 1'b0;
         case (state_q)
            S_LOCK: begin
               chipSel_n_q  <= 1'b1;
               wrStrobe_n_q <= 1'b1;
               if (cnt_q >= cyc(`EPW_LOCK_CYC)) begin
                  cnt_q   <= 20'h00000;
                  busy_q  <= 1'b0;
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q + 20'h00001;
               end
            end
            S_IDLE: begin
               if (startReq && byteCount != 6'h00 &&
                   byteCount <= `EPW_PAGE_BYTES) begin
                  busy_q   <= 1'b1;
                  left_q   <= byteCount;
                  ceMode_q <= ceMode;
                  poll_q   <= usePoll;
                  gap_q    <= 20'h00000;
                  state_q  <= S_WAIT;
               end
            end
            S_WAIT: begin
               // ready stands until a byte is taken
               byteReady_q <= 1'b1;
               gap_q       <= gap_q + 20'h00001;
               if (byteValid && byteReady_q) begin
                  byteReady_q <= 1'b0;
                  addr_q     <= {pageRow, colIn};
                  dataOut_q  <= dataIn;
                  lastTop_q  <= dataIn[`EPW_TOP_BIT];
                  dataOe_n_q <= 1'b0;
                  outGate_n_q <= 1'b1;
                  chipSel_n_q <= ceMode_q;
                  // select mode: strobe low first, select edges latch
                  wrStrobe_n_q <= ~ceMode_q;
                  cnt_q       <= 20'h00000;
                  state_q     <= S_SET;
               end
            end
            S_SET: begin
               cnt_q <= cnt_q + 20'h00001;
               if (cnt_q >= cyc(`EPW_SETUP_CYC)) begin
                  cnt_q <= 20'h00000;
                  if (ceMode_q) begin
                     chipSel_n_q  <= 1'b0;
                  end else begin
                     wrStrobe_n_q <= 1'b0;
                  end
                  state_q <= S_PULS;
               end
            end
            S_PULS: begin
               cnt_q <= cnt_q + 20'h00001;
               if (cnt_q >= cyc(`EPW_WP_CYC)) begin
                  cnt_q <= 20'h00000;
                  if (ceMode_q) begin
                     chipSel_n_q <= 1'b1;
                  end else begin
                     wrStrobe_n_q <= 1'b1;
                  end
                  state_q <= S_HOLD;
               end
            end
            S_HOLD: begin
               cnt_q <= cnt_q + 20'h00001;
               if (cnt_q >= cyc(`EPW_HOLD_CYC)) begin
                  cnt_q        <= 20'h00000;
                  wrStrobe_n_q <= 1'b1;
                  chipSel_n_q  <= 1'b1;
                  dataOe_n_q   <= 1'b1;
                  gap_q        <= 20'h00000;
                  left_q       <= left_q - 6'h01;
                  if (left_q == 6'h01) begin
                     state_q <= S_RDA;
                  end else begin
                     state_q <= S_WAIT;
                  end
               end
            end
            S_RDA: begin
               gap_q <= gap_q + 20'h00001;
               if (gap_q >= cyc(`EPW_GAP_CYC)) begin
                  cnt_q   <= 20'h00000;
                  // gap timer now measures the write period
                  gap_q   <= 20'h00000;
                  state_q <= S_RDB;
               end
            end
            S_RDB: begin
               cnt_q <= cnt_q + 20'h00001;
               gap_q <= gap_q + 20'h00001;
               if (poll_q) begin
                  chipSel_n_q <= 1'b0;
                  outGate_n_q <= 1'b0;
                  if (cnt_q >= cyc(`EPW_POLL_CYC)) begin
                     state_q <= S_RDC;
                  end
               end else begin
                  if (rdySync && cnt_q >= cyc(`EPW_POLL_CYC)) begin
                     state_q <= S_DONE;
                  end
               end
               if (gap_q >= cyc(`EPW_TWC_CYC)) begin
                  state_q <= S_DONE;
               end
            end
            S_RDC: begin
               chipSel_n_q <= 1'b1;
               outGate_n_q <= 1'b1;
               // each poll waits out the synchroniser again
               cnt_q       <= 20'h00000;
               gap_q       <= gap_q + 20'h00001;
               if (dataSync[`EPW_TOP_BIT] == lastTop_q) begin
                  state_q <= S_DONE;
               end else begin
                  state_q <= S_RDB;
               end
            end
            S_DONE: begin
               chipSel_n_q <= 1'b1;
               outGate_n_q <= 1'b1;
               busy_q      <= 1'b0;
               done_q      <= 1'b1;
               state_q     <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
         if (state_q == S_IDLE) begin
            gap_q <= 20'h00000;
         end
      end
   end
endmodule

// ### epw_host_sva.sv
/* pin sequencing checker for epw_host.
 bound to the host; sees its ports only. */
`timescale 1ns/1ns
`include "epw_consts.vh"
module epw_host_chk (
   input wire        clk,
   input wire        arst_n,
   input wire        ceMode,
   input wire        busy_q,
   input wire        done_q,
   input wire [12:0] addr_q,
   input wire        dataOe_n_q,
   input wire        chipSel_n_q,
   input wire        outGate_n_q,
   input wire        wrStrobe_n_q
);
   reg  [19:0] lockCnt_q;
   wire        wr = !wrStrobe_n_q && !chipSel_n_q;
   // =========
   // cycles since reset, stopping at the lockout count
   always @(posedge clk or negedge arst_n)
      if (!arst_n)
         lockCnt_q <= 20'h0;
      else if (lockCnt_q < `EPW_LOCK_CYC)
         lockCnt_q <= lockCnt_q + 20'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_lock_no_write: assert property (lockCnt_q < `EPW_LOCK_CYC |-> !wr)
      else $error("write in lockout");
   a_we_sel: assert property (!wrStrobe_n_q && !ceMode |-> !chipSel_n_q)
      else $error("strobe without select");
   a_data_driven: assert property (wr |-> !dataOe_n_q)
      else $error("data not driven");
   a_addr_held: assert property (wr |=> $stable(addr_q))
      else $error("address moved");
   a_pulse_wide: assert property ($rose(wr) |-> wr [*2])
      else $error("strobe too short");
   a_idle_quiet: assert property (!busy_q |-> chipSel_n_q && wrStrobe_n_q)
      else $error("pins active when idle");
   a_done_single: assert property (done_q |=> !done_q && !busy_q)
      else $error("done not single");
   a_gate_read: assert property (!outGate_n_q |-> wrStrobe_n_q && dataOe_n_q)
      else $error("gate low while writing");
endmodule
bind epw_host epw_host_chk u_chk (.*);

// ### epw_dev.sv
/* behavioural page-write eeprom.
 bench resolves data bus and pull-up. */
`timescale 1ns/1ns
module epw_dev #(
   parameter integer LOAD_NS = 10000,
   parameter integer TWC_NS  = 40000,
   parameter integer LOCK_NS = 200000
) (
   input  wire [12:0] addr,
   input  wire [7:0]  din,
   input  wire        sel_n,
   input  wire        gate_n,
   input  wire        strb_n,
   output wire [7:0]  dout,
   output wire [7:0]  doe,
   output wire        pullLow
);
   reg  [7:0]  mem [0:8191];
   reg  [7:0]  lat [0:31];
   reg  [31:0] ld = 0;
   reg  [12:0] a = 0;
   reg  [7:0]  last = 0;
   reg         busy = 0;
   reg         loading = 0;
   time        tf = 0;
   time        tr = 0;
   integer     i;
   wire        stb = !sel_n && !strb_n && gate_n;
   initial for (i = 0; i < 8192; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
   assign doe = (sel_n || gate_n || !strb_n) ? 8'h00 : (busy || loading) ? 8'h80 : 8'hFF;
   assign dout = (busy || loading) ? {~last[7], 7'h00} : mem[addr];
   assign pullLow = busy;
   always @(posedge stb) begin
      tf = $time;
      if (!busy) a = addr;
   end
   always @(negedge stb)
      if (!busy && $time >= LOCK_NS && $time - tf >= 20) begin
         lat[a[4:0]] = din;
         ld[a[4:0]] = 1'b1;
         last = din;
         loading = 1'b1;
         tr = $time;
      end
   always #100
      if (loading && !stb && $time - tr > LOAD_NS) begin
         loading = 1'b0;
         busy = 1'b1;
         #(TWC_NS);
         for (i = 0; i < 32; i = i + 1)
            if (ld[i]) mem[{a[12:5], i[4:0]}] = lat[i];
         ld = 0;
         busy = 1'b0;
      end
endmodule

// ### tb_epw_host.sv
/* bench of epw_host against epw_dev.
 checker bound separately. */
`timescale 1ns/1ns
module tb_epw_host;
   reg         clk = 0, arst_n = 0, startReq = 0, ceMode = 0, usePoll = 1, byteValid = 0;
   reg  [7:0]  pageRow = 0, dataIn = 0, noise = 0;
   reg  [5:0]  byteCount = 0;
   reg  [4:0]  colIn = 0;
   wire        byteReady_q, busy_q, done_q, dataOe_n_q, chipSel_n_q, outGate_n_q;
   wire        wrStrobe_n_q, pullLow;
   wire [12:0] addr_q;
   wire [7:0]  dataOut_q, dOut, dDrv;
   // released lines show a changing pattern
   wire [7:0]  dataPin = !dataOe_n_q ? dataOut_q : (dDrv & dOut) | (~dDrv & noise);
   wire        writeDonePin = pullLow ? 1'b0 : 1'b1;
   integer     err_total = 0, n_checks = 0, k;
   epw_host u_dut (.*);
   epw_dev u_dev (.addr(addr_q), .din(dataPin), .sel_n(chipSel_n_q), .gate_n(outGate_n_q),
      .strb_n(wrStrobe_n_q), .dout(dOut), .doe(dDrv), .pullLow(pullLow));
   initial forever #25 clk = ~clk;
   always @(posedge clk) noise <= noise + 8'h5B;
   task end_of_test;
      begin
         if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            $display("wrong value %0s exp %h got %h", nm, e, g);
            err_total = err_total + 1;
         end
      end
   endtask
   // sel 0 waits busy low, sel 1 a done pulse
   task waitFor(input sel, input integer n);
      begin
         k = 0;
         do begin
            @(posedge clk);
            #1;
            k = k + 1;
         end while ((sel ? done_q : !busy_q) !== 1'b1 && k <= n);
         if (k > n) begin
            chk("timeout", 8'h00, 8'h01);
            end_of_test;
         end
      end
   endtask
   task start(input [7:0] row, input [5:0] cnt, input ce, input poll);
      begin
         @(posedge clk);
         #2;
         pageRow = row;
         byteCount = cnt;
         ceMode = ce;
         usePoll = poll;
         startReq = 1;
         @(posedge clk);
         #2;
         startReq = 0;
      end
   endtask
   task sendB(input [4:0] c, input [7:0] d);
      begin
         @(posedge clk);
         #2;
         colIn = c;
         dataIn = d;
         byteValid = 1;
         k = 0;
         while (byteReady_q !== 1'b1 && k < 500) begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         if (k >= 500) begin
            chk("readyTimeout", 8'h00, 8'h01);
            end_of_test;
         end
         chk("ready", 8'h01, {7'h00, byteReady_q});
         @(posedge clk);
         #2;
         byteValid = 0;
         chk("readyLow", 8'h00, {7'h00, byteReady_q});
      end
   endtask
   task s_page;
      begin
         start(8'h12, 6'h03, 1'b0, 1'b1);
         sendB(5'h05, 8'hA1);
         sendB(5'h02, 8'hB2);
         sendB(5'h05, 8'h43);
         waitFor(1'b1, 5000);
         chk("devBusy", 8'h00, {7'h00, u_dev.busy});
         chk("col5", 8'h43, u_dev.mem[13'h0245]);
         chk("col2", 8'hB2, u_dev.mem[13'h0242]);
         chk("col3", 8'h19, u_dev.mem[13'h0243]);
      end
   endtask
   task s_byteCe;
      begin
         start(8'hFF, 6'h01, 1'b1, 1'b0);
         sendB(5'h1F, 8'h0F);
         waitFor(1'b1, 5000);
         chk("devBusy", 8'h00, {7'h00, u_dev.busy});
         chk("col31", 8'h0F, u_dev.mem[13'h1FFF]);
         chk("col30", 8'hA4, u_dev.mem[13'h1FFE]);
      end
   endtask
   task s_refuse;
      begin
         start(8'h01, 6'h00, 1'b0, 1'b1);
         chk("busyCnt0", 8'h00, {7'h00, busy_q});
         start(8'h01, 6'h21, 1'b0, 1'b1);
         chk("busyCnt33", 8'h00, {7'h00, busy_q});
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #2;
      arst_n = 1;
      chk("lockBusy", 8'h01, {7'h00, busy_q});
      waitFor(1'b0, 110000);
      s_page;
      s_byteCe;
      s_refuse;
      end_of_test;
   end
endmodule
